/* File: core/dea_pkg.sv */
// constants shared by the data memory access control block
package dea_pkg;
	// register offsets on the 4-bit register port
	localparam logic [3:0] OFS_CONTROL = 4'h0;
	localparam logic [3:0] OFS_ADDRESS = 4'h1;
	localparam logic [3:0] OFS_DATA = 4'h2;
	localparam logic [3:0] OFS_UNLOCK = 4'h3;
	localparam logic [3:0] OFS_IRQ_STATUS = 4'h4;
	localparam logic [3:0] OFS_IRQ_MASK = 4'h5;
	// nv_control field positions
	localparam int BIT_PGM_SEL = 7;
	localparam int BIT_PERMIT = 2;
	localparam int BIT_WR_LAUNCH = 1;
	localparam int BIT_RD_LAUNCH = 0;
	// irq status and mask field positions
	localparam int BIT_WRITE_DONE = 0;
	// reset values
	localparam logic [7:0] RST_BYTE = 8'h00;
	// unlock keys
	localparam logic [7:0] UNLOCK_KEY_FIRST = 8'h55;
	localparam logic [7:0] UNLOCK_KEY_SECOND = 8'hAA;
	// memory geometry
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam int MEM_DEPTH = 256;
	// write cycle timing
	localparam int CLK_PERIOD_NS = 100;
	localparam int WRITE_TIME_NS = 5000;
	localparam int WRITE_CYCLES_INT =
		(WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [7:0] WRITE_CYCLES = WRITE_CYCLES_INT[7:0];
	localparam logic [7:0] CNT_ONE = 8'h01;
	localparam logic [7:0] CNT_ZERO = 8'h00;
	// unlock sequence tracker
	typedef enum logic [1:0] {
		LOCK_IDLE,
		LOCK_GOT_FIRST,
		LOCK_ARMED
	} dea_lock_e;
endpackage : dea_pkg

/* File: core/dea_mem.sv */
// byte-wide nonvolatile data array, one write port, combinational read
`timescale 1ns/1ns
`default_nettype none
module dea_mem (
	// clock
	input wire logic ref_clk,
	// write port
	input wire logic wr_en,
	input wire logic [dea_pkg::ADDR_W-1:0] wr_addr,
	input wire logic [dea_pkg::DATA_W-1:0] wr_data,
	// read port
	input wire logic [dea_pkg::ADDR_W-1:0] rd_addr,
	output logic [dea_pkg::DATA_W-1:0] rd_data
);
	// no reset: cell contents survive a system reset
	logic [dea_pkg::DATA_W-1:0] cells [dea_pkg::MEM_DEPTH];

	always_ff @(posedge ref_clk) begin
		if (wr_en) begin
			cells[wr_addr] <= wr_data;
		end
	end

	assign rd_data = cells[rd_addr];
endmodule : dea_mem
`default_nettype wire

/* File: core/dea_ctrl.sv */
// data memory access control: registers, unlock, write timer, interrupt
// Functional notes
// - program space select ignores write launch
// - write launch starts cycle, hardware clears it
// - software sets write launch, never clears
// - write launch reads zero when idle
// - read launch starts read, self clears
// - read byte ready for next instruction
// - data register holds until read or written
// - launch needs permit set; permit never auto-cleared
// - write needs 55h, AAh, then launch
// - completion sets sticky write done flag
// - clearing permit does not abort write
//
// Our own choices: strobed register access and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module dea_ctrl (
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset_n,
	// register port
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [7:0] reg_rdata,
	// interrupt
	output logic irq
);
	logic pgm_sel_reg;
	logic permit_reg;
	logic wr_reg;
	logic rd_reg;
	logic [7:0] addr_reg;
	logic [7:0] data_reg;
	logic [7:0] wr_addr_reg;
	logic [7:0] wr_data_reg;
	logic [7:0] cnt_reg;
	logic [7:0] status_reg;
	logic [7:0] status_next;
	logic [7:0] mask_reg;
	logic [7:0] rdata_next;
	logic [7:0] mem_rdata;
	dea_pkg::dea_lock_e lock_reg;
	logic wr_ctrl;
	logic wr_unlock;
	logic launch_ok;
	logic rd_launch;
	logic write_done;

	assign wr_ctrl = reg_write && (reg_addr == dea_pkg::OFS_CONTROL);
	assign wr_unlock = reg_write && (reg_addr == dea_pkg::OFS_UNLOCK);
	// launch accepted only from an armed unlock, with permit already set
	assign launch_ok = wr_ctrl && reg_wdata[dea_pkg::BIT_WR_LAUNCH]
		&& !reg_wdata[dea_pkg::BIT_PGM_SEL]
		&& permit_reg
		&& (lock_reg == dea_pkg::LOCK_ARMED)
		&& !wr_reg;
	// program memory path is absent, so only data space reads load data
	assign rd_launch = wr_ctrl && reg_wdata[dea_pkg::BIT_RD_LAUNCH]
		&& !reg_wdata[dea_pkg::BIT_PGM_SEL];
	assign write_done = wr_reg && (cnt_reg == dea_pkg::CNT_ONE);

	dea_mem i_dea_mem (
		.ref_clk(ref_clk),
		.wr_en(write_done),
		.wr_addr(wr_addr_reg),
		.wr_data(wr_data_reg),
		.rd_addr(addr_reg),
		.rd_data(mem_rdata)
	);

	// unlock sequence: a bus write out of order drops back to idle, except a repeated 55h key, which keeps the first key
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			lock_reg <= dea_pkg::LOCK_IDLE;
		end else if (reg_write) begin
			case (lock_reg)
				dea_pkg::LOCK_IDLE: begin
					if (wr_unlock && reg_wdata == dea_pkg::UNLOCK_KEY_FIRST) begin
						lock_reg <= dea_pkg::LOCK_GOT_FIRST;
					end
				end
				dea_pkg::LOCK_GOT_FIRST: begin
					if (wr_unlock && reg_wdata == dea_pkg::UNLOCK_KEY_SECOND) begin
						lock_reg <= dea_pkg::LOCK_ARMED;
					end else if (wr_unlock
						&& reg_wdata == dea_pkg::UNLOCK_KEY_FIRST) begin
						lock_reg <= dea_pkg::LOCK_GOT_FIRST;
					end else begin
						lock_reg <= dea_pkg::LOCK_IDLE;
					end
				end
				default: begin
					// one launch attempt per unlock, whatever its outcome
					lock_reg <= dea_pkg::LOCK_IDLE;
				end
			endcase
		end
	end

	// mode bits: plain software fields, hardware never touches permit
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			pgm_sel_reg <= 1'b0;
			permit_reg <= 1'b0;
		end else if (wr_ctrl) begin
			pgm_sel_reg <= reg_wdata[dea_pkg::BIT_PGM_SEL];
			permit_reg <= reg_wdata[dea_pkg::BIT_PERMIT];
		end
	end

	// write launch and programming timer
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			wr_reg <= 1'b0;
			cnt_reg <= dea_pkg::CNT_ZERO;
			wr_addr_reg <= dea_pkg::RST_BYTE;
			wr_data_reg <= dea_pkg::RST_BYTE;
		end else if (launch_ok) begin
			wr_reg <= 1'b1;
			cnt_reg <= dea_pkg::WRITE_CYCLES;
			// latched so later register writes cannot disturb the cycle
			wr_addr_reg <= addr_reg;
			wr_data_reg <= data_reg;
		end else if (wr_reg) begin
			// zero writes and permit changes also reach here and leave the countdown running
			cnt_reg <= cnt_reg - dea_pkg::CNT_ONE;
			if (write_done) begin
				wr_reg <= 1'b0;
			end
		end
	end

	// read launch bit: set by software, gone one cycle later
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			rd_reg <= 1'b0;
		end else begin
			rd_reg <= wr_ctrl && reg_wdata[dea_pkg::BIT_RD_LAUNCH];
		end
	end

	// address and data registers
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			addr_reg <= dea_pkg::RST_BYTE;
			data_reg <= dea_pkg::RST_BYTE;
		end else begin
			if (reg_write && reg_addr == dea_pkg::OFS_ADDRESS) begin
				addr_reg <= reg_wdata;
			end
			if (rd_launch) begin
				data_reg <= mem_rdata;
			end else if (reg_write && reg_addr == dea_pkg::OFS_DATA) begin
				data_reg <= reg_wdata;
			end
		end
	end

	// sticky status: a completion in the clearing cycle wins
	always_comb begin
		status_next = status_reg;
		if (reg_write && reg_addr == dea_pkg::OFS_IRQ_STATUS) begin
			status_next = status_reg & ~reg_wdata;
		end
		if (write_done) begin
			status_next[dea_pkg::BIT_WRITE_DONE] = 1'b1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			status_reg <= dea_pkg::RST_BYTE;
			mask_reg <= dea_pkg::RST_BYTE;
			irq <= 1'b0;
		end else begin
			status_reg <= status_next;
			if (reg_write && reg_addr == dea_pkg::OFS_IRQ_MASK) begin
				mask_reg <= reg_wdata;
			end
			// registered output, so it trails the status bit by one cycle
			irq <= |(status_reg & mask_reg);
		end
	end

	// read mux; unlock port and unmapped offsets read zero
	always_comb begin
		rdata_next = dea_pkg::RST_BYTE;
		if (reg_addr == dea_pkg::OFS_CONTROL) begin
			rdata_next[dea_pkg::BIT_PGM_SEL] = pgm_sel_reg;
			rdata_next[dea_pkg::BIT_PERMIT] = permit_reg;
			rdata_next[dea_pkg::BIT_WR_LAUNCH] = wr_reg;
			rdata_next[dea_pkg::BIT_RD_LAUNCH] = rd_reg;
		end else if (reg_addr == dea_pkg::OFS_ADDRESS) begin
			rdata_next = addr_reg;
		end else if (reg_addr == dea_pkg::OFS_DATA) begin
			rdata_next = data_reg;
		end else if (reg_addr == dea_pkg::OFS_IRQ_STATUS) begin
			rdata_next = status_reg;
		end else if (reg_addr == dea_pkg::OFS_IRQ_MASK) begin
			rdata_next = mask_reg;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			reg_rdata <= dea_pkg::RST_BYTE;
		end else if (reg_read) begin
			reg_rdata <= rdata_next;
		end else begin
			reg_rdata <= dea_pkg::RST_BYTE;
		end
	end

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!reset_n);

	sequence unlocked_s;
		lock_reg == dea_pkg::LOCK_ARMED;
	endsequence
	sequence launch_s;
		wr_ctrl && reg_wdata[dea_pkg::BIT_WR_LAUNCH] && permit_reg && !wr_reg
			&& !reg_wdata[dea_pkg::BIT_PGM_SEL];
	endsequence
	sequence key_second_s;
		wr_unlock && reg_wdata == dea_pkg::UNLOCK_KEY_SECOND;
	endsequence

	pgm_space_block_a: assert property (
		(wr_ctrl && reg_wdata[dea_pkg::BIT_PGM_SEL] && !wr_reg) |=> !wr_reg)
		else $error("write started with program space selected");
	write_start_a: assert property (
		(unlocked_s and launch_s) |=> wr_reg ##[1:60] !wr_reg)
		else $error("write launch did not start and finish");
	no_sw_clear_a: assert property (
		(wr_reg && cnt_reg > dea_pkg::CNT_ONE) |=> wr_reg)
		else $error("write launch bit dropped early");
	launch_readback_a: assert property (
		reg_read && reg_addr == dea_pkg::OFS_CONTROL
		|=> reg_rdata[dea_pkg::BIT_WR_LAUNCH] == $past(wr_reg))
		else $error("write launch bit reads wrong");
	read_self_clear_a: assert property (
		rd_reg && !wr_ctrl |=> !rd_reg)
		else $error("read launch bit did not clear");
	read_data_next_a: assert property (
		rd_launch |=> data_reg == $past(mem_rdata))
		else $error("read byte not in data register");
	data_hold_a: assert property (
		!rd_launch && !(reg_write && reg_addr == dea_pkg::OFS_DATA)
		|=> $stable(data_reg))
		else $error("data register changed without cause");
	permit_gate_a: assert property (
		$rose(wr_reg) |-> $past(permit_reg))
		else $error("write started without permit");
	permit_keep_a: assert property (
		permit_reg && !wr_ctrl |=> permit_reg)
		else $error("permit cleared by hardware");
	unlock_order_a: assert property (
		$rose(wr_reg) |-> $past(lock_reg) == dea_pkg::LOCK_ARMED)
		else $error("write started without unlock sequence");
	done_flag_a: assert property (
		$fell(wr_reg) |-> status_reg[dea_pkg::BIT_WRITE_DONE])
		else $error("write done flag not set");
	permit_no_abort_a: assert property (
		wr_reg && wr_ctrl && !reg_wdata[dea_pkg::BIT_PERMIT]
		&& cnt_reg > dea_pkg::CNT_ONE |=> wr_reg)
		else $error("clearing permit aborted write");
	write_length_a: assert property (
		$rose(wr_reg) |-> cnt_reg == dea_pkg::WRITE_CYCLES ##50 $fell(wr_reg))
		else $error("write cycle length wrong");
	count_down_a: assert property (
		wr_reg && !write_done
		|=> wr_reg && cnt_reg == $past(cnt_reg) - dea_pkg::CNT_ONE)
		else $error("write timer skipped or stalled");
	launch_clear_a: assert property (
		write_done |=> !wr_reg && status_reg[dea_pkg::BIT_WRITE_DONE])
		else $error("write launch bit not cleared at completion");
	done_sticky_a: assert property (
		status_reg[dea_pkg::BIT_WRITE_DONE]
		&& !(reg_write && reg_addr == dea_pkg::OFS_IRQ_STATUS
		&& reg_wdata[dea_pkg::BIT_WRITE_DONE])
		|=> status_reg[dea_pkg::BIT_WRITE_DONE])
		else $error("write done flag cleared without software");
	irq_on_a: assert property (
		(status_reg & mask_reg) != dea_pkg::RST_BYTE |=> irq)
		else $error("interrupt low with unmasked status set");
	irq_off_a: assert property (
		(status_reg & mask_reg) == dea_pkg::RST_BYTE |=> !irq)
		else $error("interrupt high with no unmasked status");
	unlock_arm_a: assert property (
		(lock_reg == dea_pkg::LOCK_GOT_FIRST) ##0 key_second_s
		|=> unlocked_s)
		else $error("unlock keys in order did not arm");
	unlock_lapse_a: assert property (
		unlocked_s ##0 reg_write |=> lock_reg == dea_pkg::LOCK_IDLE)
		else $error("unlock stayed armed after a bus write");
	read_launch_set_a: assert property (
		wr_ctrl && reg_wdata[dea_pkg::BIT_RD_LAUNCH] |=> rd_reg)
		else $error("read launch bit not set by software");
endmodule : dea_ctrl
`default_nettype wire

/* File: testbench/tb_dea_ctrl.sv */
// self-checking bench for the data memory access control block
`timescale 1ns/1ns
`default_nettype none
module tb_dea_ctrl;
	logic ref_clk = 1'b0;
	logic reset_n = 1'b0;
	logic [3:0] reg_addr = 4'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_write = 1'b0;
	logic reg_read = 1'b0;
	logic [7:0] reg_rdata;
	logic irq;
	int n_errors = 0;
	int comparisons = 0;
	// refused launches: control before, unlock style, launch value, expected
	logic [7:0] c_pre [5] = '{8'h00, 8'h04, 8'h84, 8'h04, 8'h00};
	logic [1:0] c_mode [5] = '{2'h0, 2'h1, 2'h0, 2'h2, 2'h0};
	logic [7:0] c_go [5] = '{8'h06, 8'h06, 8'h86, 8'h06, 8'h02};
	logic [7:0] c_exp [5] = '{8'h04, 8'h04, 8'h84, 8'h04, 8'h00};

	dea_ctrl i_dea_ctrl (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_write(reg_write),
		.reg_read(reg_read),
		.reg_rdata(reg_rdata),
		.irq(irq)
	);

	always #50 ref_clk = ~ref_clk;

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// one idle cycle before each strobe keeps every driver edge distinct
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_write <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_write <= 1'b0;
	endtask : wr

	task automatic rd(input logic [3:0] a, input logic [7:0] exp);
		@(posedge ref_clk);
		reg_read <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_read <= 1'b0;
		@(negedge ref_clk);
		chk(reg_rdata, exp);
	endtask : rd

	task automatic finish_test;
		$display("comparisons %0d mismatches %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : finish_test

	initial begin
		repeat (3000) @(posedge ref_clk);
		n_errors++;
		finish_test();
	end

	initial begin
		repeat (10) @(posedge ref_clk);
		reset_n <= 1'b1;
		for (int i = 0; i < 6; i++) begin
			rd(i[3:0], 8'h00);
		end
		wr(4'hF, 8'hFF);
		rd(4'hF, 8'h00);
		$display("test reset_and_unmapped done");

		wr(dea_pkg::OFS_ADDRESS, 8'h3C);
		wr(dea_pkg::OFS_DATA, 8'hA5);
		wr(dea_pkg::OFS_CONTROL, 8'h04);
		wr(dea_pkg::OFS_UNLOCK, dea_pkg::UNLOCK_KEY_FIRST);
		wr(dea_pkg::OFS_UNLOCK, dea_pkg::UNLOCK_KEY_SECOND);
		rd(dea_pkg::OFS_UNLOCK, 8'h00);
		wr(dea_pkg::OFS_CONTROL, 8'h06);
		// zero to launch and permit: write must go on
		wr(dea_pkg::OFS_CONTROL, 8'h00);
		rd(dea_pkg::OFS_CONTROL, 8'h02);
		// reads straddle the edge at which the 50-cycle timer ends
		repeat (44) @(posedge ref_clk);
		rd(dea_pkg::OFS_CONTROL, 8'h02);
		rd(dea_pkg::OFS_CONTROL, 8'h00);
		rd(dea_pkg::OFS_IRQ_STATUS, 8'h01);
		chk({7'h00, irq}, 8'h00);
		wr(dea_pkg::OFS_IRQ_MASK, 8'h01);
		// irq is registered from the mask, so it rises one edge later
		@(posedge ref_clk);
		@(negedge ref_clk);
		chk({7'h00, irq}, 8'h01);
		wr(dea_pkg::OFS_IRQ_STATUS, 8'h00);
		rd(dea_pkg::OFS_IRQ_STATUS, 8'h01);
		wr(dea_pkg::OFS_IRQ_STATUS, 8'h01);
		rd(dea_pkg::OFS_IRQ_STATUS, 8'h00);
		chk({7'h00, irq}, 8'h00);
		$display("test write_cycle done");

		wr(dea_pkg::OFS_DATA, 8'h00);
		wr(dea_pkg::OFS_ADDRESS, 8'h3C);
		wr(dea_pkg::OFS_CONTROL, 8'h01);
		rd(dea_pkg::OFS_DATA, 8'hA5);
		rd(dea_pkg::OFS_CONTROL, 8'h00);
		wr(dea_pkg::OFS_ADDRESS, 8'h11);
		rd(dea_pkg::OFS_DATA, 8'hA5);
		$display("test data_read done");

		for (int i = 0; i < 5; i++) begin
			wr(dea_pkg::OFS_CONTROL, c_pre[i]);
			if (c_mode[i] != 2'h1) begin
				wr(dea_pkg::OFS_UNLOCK, dea_pkg::UNLOCK_KEY_FIRST);
			end
			if (c_mode[i] == 2'h2) begin
				wr(dea_pkg::OFS_ADDRESS, 8'h3C);
			end
			if (c_mode[i] != 2'h1) begin
				wr(dea_pkg::OFS_UNLOCK, dea_pkg::UNLOCK_KEY_SECOND);
			end
			wr(dea_pkg::OFS_CONTROL, c_go[i]);
			rd(dea_pkg::OFS_CONTROL, c_exp[i]);
			repeat (55) @(posedge ref_clk);
			rd(dea_pkg::OFS_IRQ_STATUS, 8'h00);
		end
		$display("test refused_launch done");
		finish_test();
	end
endmodule : tb_dea_ctrl
`default_nettype wire
